// ---- ppw_pkg.sv ----
// Package: register map, reset values and field positions of the port pull-up/mask block
package ppw_pkg;
    // ==========================================================
    // Register word indices: the byte address is four times the index
    localparam logic [7:0] PPW_OFF_MASK   = 8'h84;
    localparam logic [7:0] PPW_OFF_SEL    = 8'h85;
    localparam logic [7:0] PPW_OFF_P0PU   = 8'hb9;
    localparam logic [7:0] PPW_OFF_P1PU   = 8'hba;
    localparam logic [7:0] PPW_OFF_P3PU   = 8'hbc;
    localparam logic [7:0] PPW_OFF_STATUS = 8'hc0;
    // ==========================================================
    // Reset values
    localparam logic [7:0] PPW_RST_MASK = 8'hff;
    localparam logic [7:0] PPW_RST_SEL  = 8'h00;
    localparam logic [7:0] PPW_RST_P0PU = 8'h00;
    localparam logic [6:0] PPW_RST_P1PU = 7'h00;
    localparam logic [7:0] PPW_RST_P3PU = 8'h00;
    // ==========================================================
    // Field positions in the input selection register
    localparam int PPW_SEL_COMBINE = 0;
    localparam int PPW_SEL_WAKE    = 1;
    localparam int PPW_SEL_W       = 2;
    // Status register bit positions
    localparam int PPW_ST_COMBINED = 0;
    localparam int PPW_ST_WAKE     = 1;
    localparam int PPW_ST_PIN7     = 2;
    // ==========================================================
    // AHB-Lite encodings
    localparam logic [1:0]  PPW_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  PPW_HTRANS_SEQ    = 2'h3;
    localparam logic [2:0]  PPW_HSIZE_WORD    = 3'h2;
    localparam logic [31:0] PPW_ZERO_WORD     = 32'h0000_0000;
    localparam int          PPW_ADDR_W        = 8;
    localparam int          PPW_IDX_LSB       = 2;

    typedef enum logic [0:0] {
        PPW_IDLE = 1'b0,
        PPW_DATA = 1'b1
    } ppw_bus_st_t;
endpackage : ppw_pkg

// ---- ppw_ctl_if.sv ----
// Interface: control values passed from the register file to the pin logic
`timescale 1ns/100ps
interface ppw_ctl_if;
    import ppw_pkg::*;
    logic [7:0] mask;
    logic [7:0] sel;
    logic [7:0] p0_pu;
    logic [6:0] p1_pu;
    logic [7:0] p3_pu;
    logic       combined;
    logic       wake;
    logic       pin7;
    modport regs (output mask, output sel, output p0_pu, output p1_pu, output p3_pu,
                  input combined, input wake, input pin7);
    modport pins (input mask, input sel, input p0_pu, input p1_pu, input p3_pu,
                  output combined, output wake, output pin7);
endinterface : ppw_ctl_if

// ---- ppw_pin_logic.sv ----
// Pin logic: pull-up drives, port 0 combining, port 1 pin 7 output and wake select
`timescale 1ns/100ps
module ppw_pin_logic
    import ppw_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  rst,
    ppw_ctl_if.pins    ctl,
    input  wire logic [7:0] port0_in,
    input  wire logic  port1_pin7_latch,
    input  wire logic  ext_irq_line_a,
    input  wire logic  ext_irq_line_b,
    input  wire logic  sleep_wake,
    output logic [7:0] port0_pullup_en,
    output logic [6:0] port1_pullup_en,
    output logic [7:0] port3_pullup_en,
    output logic       port1_pin7_out,
    output logic       core_wake
);
    // ==========================================================
    // Per-bit pull-up enables and masked inputs
    logic [7:0] masked;
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            assign port0_pullup_en[i] = ~ctl.p0_pu[i];
            assign port3_pullup_en[i] = ~ctl.p3_pu[i];
            assign masked[i]          = port0_in[i] | ctl.mask[i];
            if (i < 7) begin : g_p1
                assign port1_pullup_en[i] = ~ctl.p1_pu[i];
            end
        end
    endgenerate

    // ==========================================================
    // Registered pin 7 and wake outputs
    logic pin7_r, pin7_nxt, wake_r, wake_nxt;
    always_comb begin
        pin7_nxt = ctl.sel[PPW_SEL_COMBINE] ? (&masked)
                                            : port1_pin7_latch;
        wake_nxt = ctl.sel[PPW_SEL_WAKE] ? sleep_wake
                                         : (ext_irq_line_a | ext_irq_line_b);
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin7_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            pin7_r <= pin7_nxt;
            wake_r <= wake_nxt;
        end
    end
    // Pin 7 is drive-only: no enable and no input path
    assign port1_pin7_out = pin7_r;
    assign core_wake      = wake_r;
    assign ctl.combined   = &masked;
    assign ctl.wake       = wake_r;
    assign ctl.pin7       = pin7_r;
endmodule // ppw_pin_logic

// ---- ppw_top.sv ----
// Top: AHB-Lite register file for port pull-ups, port 0 mask/combine and wake select
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module ppw_top
    import ppw_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  port0_in,
    input  wire logic        port1_pin7_latch,
    input  wire logic        ext_irq_line_a,
    input  wire logic        ext_irq_line_b,
    input  wire logic        sleep_wake,
    output logic      [7:0]  port0_pullup_en,
    output logic      [6:0]  port1_pullup_en,
    output logic      [7:0]  port3_pullup_en,
    output logic             port1_pin7_out,
    output logic             core_wake
);
    ppw_ctl_if ctl ();

    // ==========================================================
    // Registers
    logic [7:0]          mask_r, mask_nxt;
    logic [PPW_SEL_W-1:0] sel_r, sel_nxt;
    logic [7:0]          p0pu_r, p0pu_nxt;
    logic [6:0]          p1pu_r, p1pu_nxt;
    logic [7:0]          p3pu_r, p3pu_nxt;

    // ==========================================================
    // Bus address phase capture
    ppw_bus_st_t          st_r, st_nxt;
    logic [PPW_ADDR_W-1:0] addr_r, addr_nxt;
    logic                 wr_r, wr_nxt;
    logic [31:0]          rdata_r, rdata_nxt;
    logic                 take;
    logic [7:0]           wb;
    logic [PPW_ADDR_W-1:0] idx;
    logic [31:0]          status_w;

    assign take = hsel & hready & (htrans == PPW_HTRANS_NONSEQ || htrans == PPW_HTRANS_SEQ);
    assign wb   = hwdata[7:0];
    // Each register owns one aligned word, so the decode uses the word index only
    assign idx  = haddr[PPW_ADDR_W+PPW_IDX_LSB-1:PPW_IDX_LSB];

    // ==========================================================
    // Live status word
    always_comb begin
        status_w                  = PPW_ZERO_WORD;
        status_w[PPW_ST_COMBINED] = ctl.combined;
        status_w[PPW_ST_WAKE]     = ctl.wake;
        status_w[PPW_ST_PIN7]     = ctl.pin7;
    end

    // Read mux: unmapped addresses read zero
    function automatic logic [31:0] rd_word(input logic [PPW_ADDR_W-1:0] a);
        logic [31:0] w;
        w = PPW_ZERO_WORD;
        if (a == PPW_OFF_MASK) begin
            w[7:0] = mask_r;
        end else if (a == PPW_OFF_SEL) begin
            w[PPW_SEL_W-1:0] = sel_r;
        end else if (a == PPW_OFF_P0PU) begin
            w[7:0] = p0pu_r;
        end else if (a == PPW_OFF_P1PU) begin
            w[6:0] = p1pu_r;
        end else if (a == PPW_OFF_P3PU) begin
            w[7:0] = p3pu_r;
        end else if (a == PPW_OFF_STATUS) begin
            w = status_w;
        end
        return w;
    endfunction

    // ==========================================================
    // Bus state: address phase capture and registered read data
    // A read right behind a write to the same register returns the old value,
    // because read data is taken in the read's own address phase.
    always_comb begin
        st_nxt    = st_r;
        addr_nxt  = addr_r;
        wr_nxt    = wr_r;
        rdata_nxt = rdata_r;
        case (st_r)
            PPW_IDLE: begin
                if (take) begin
                    st_nxt    = PPW_DATA;
                    addr_nxt  = idx;
                    wr_nxt    = hwrite;
                    // Read data is latched so hrdata comes from a flop
                    rdata_nxt = rd_word(idx);
                end
            end
            PPW_DATA: begin
                st_nxt = take ? PPW_DATA : PPW_IDLE;
                if (take) begin
                    addr_nxt  = idx;
                    wr_nxt    = hwrite;
                    rdata_nxt = rd_word(idx);
                end
            end
            default: st_nxt = PPW_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r    <= PPW_IDLE;
            addr_r  <= '0;
            wr_r    <= 1'b0;
            rdata_r <= PPW_ZERO_WORD;
        end else begin
            st_r    <= st_nxt;
            addr_r  <= addr_nxt;
            wr_r    <= wr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ==========================================================
    // Write strobes: write data arrives in the data phase of the captured address
    logic                 wr_mask;
    logic                 wr_sel;
    logic                 wr_p0pu;
    logic                 wr_p1pu;
    logic                 wr_p3pu;

    always_comb begin
        wr_mask = 1'b0;
        wr_sel  = 1'b0;
        wr_p0pu = 1'b0;
        wr_p1pu = 1'b0;
        wr_p3pu = 1'b0;
        if (st_r == PPW_DATA && wr_r) begin
            if (addr_r == PPW_OFF_MASK) begin
                wr_mask = 1'b1;
            end else if (addr_r == PPW_OFF_SEL) begin
                wr_sel = 1'b1;
            end else if (addr_r == PPW_OFF_P0PU) begin
                wr_p0pu = 1'b1;
            end else if (addr_r == PPW_OFF_P1PU) begin
                wr_p1pu = 1'b1;
            end else if (addr_r == PPW_OFF_P3PU) begin
                wr_p3pu = 1'b1;
            end
        end
    end

    // ==========================================================
    // Control registers: unmapped writes and reserved bits are dropped
    always_comb begin
        mask_nxt = wr_mask ? wb : mask_r;
        sel_nxt  = wr_sel ? wb[PPW_SEL_W-1:0] : sel_r;
        p0pu_nxt = wr_p0pu ? wb : p0pu_r;
        p1pu_nxt = wr_p1pu ? wb[6:0] : p1pu_r;
        p3pu_nxt = wr_p3pu ? wb : p3pu_r;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            mask_r  <= PPW_RST_MASK;
            sel_r   <= PPW_RST_SEL[PPW_SEL_W-1:0];
            p0pu_r  <= PPW_RST_P0PU;
            p1pu_r  <= PPW_RST_P1PU;
            p3pu_r  <= PPW_RST_P3PU;
        end else begin
            mask_r  <= mask_nxt;
            sel_r   <= sel_nxt;
            p0pu_r  <= p0pu_nxt;
            p1pu_r  <= p1pu_nxt;
            p3pu_r  <= p3pu_nxt;
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_r;

    assign ctl.mask  = mask_r;
    assign ctl.sel   = {{(8-PPW_SEL_W){1'b0}}, sel_r};
    assign ctl.p0_pu = p0pu_r;
    assign ctl.p1_pu = p1pu_r;
    assign ctl.p3_pu = p3pu_r;

    // ==========================================================
    // Pin logic
    ppw_pin_logic u_pins (
        .mclk             (mclk),
        .rst              (rst),
        .ctl              (ctl.pins),
        .port0_in         (port0_in),
        .port1_pin7_latch (port1_pin7_latch),
        .ext_irq_line_a   (ext_irq_line_a),
        .ext_irq_line_b   (ext_irq_line_b),
        .sleep_wake       (sleep_wake),
        .port0_pullup_en  (port0_pullup_en),
        .port1_pullup_en  (port1_pullup_en),
        .port3_pullup_en  (port3_pullup_en),
        .port1_pin7_out   (port1_pin7_out),
        .core_wake        (core_wake)
    );
endmodule // ppw_top

// ---- ppw_pin_env.sv ----
// Partner model: port pins, interrupt lines and sleep timer wake
`timescale 1ns/100ps
module ppw_pin_env (
    input  wire logic [11:0] drive,
    output logic      [7:0]  port0_in,
    output logic             port1_pin7_latch,
    output logic             ext_irq_line_a,
    output logic             ext_irq_line_b,
    output logic             sleep_wake
);
    // =========
    // Pins
    assign {sleep_wake, ext_irq_line_b, ext_irq_line_a, port1_pin7_latch, port0_in} = drive;
endmodule // ppw_pin_env

// ---- ppw_top_asserts.sv ----
// Checker: pull-up, combine, pin 7 and wake relations at the top ports
`timescale 1ns/100ps
module ppw_top_asserts
    import ppw_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [7:0]  port0_in,
    input wire logic        port1_pin7_latch,
    input wire logic        ext_irq_line_a,
    input wire logic        ext_irq_line_b,
    input wire logic        sleep_wake,
    input wire logic [7:0]  port0_pullup_en,
    input wire logic [6:0]  port1_pullup_en,
    input wire logic [7:0]  port3_pullup_en,
    input wire logic        port1_pin7_out,
    input wire logic        core_wake
);
    logic       wv_r;
    logic [7:0] wa_r;
    logic [7:0] mask_r;
    logic [1:0] sel_r;
    logic       and_w;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // =========
    // Shadow of the control bits, loaded at the data phase edge as the design does
    assign and_w = &(port0_in | mask_r);
    always_ff @(posedge mclk) begin
        if (rst) begin
            wv_r <= 1'b0;
            wa_r <= 8'h00;
            mask_r <= PPW_RST_MASK;
            sel_r <= 2'h0;
        end else begin
            wv_r <= hsel && hready && htrans[1] && hwrite;
            wa_r <= haddr[PPW_ADDR_W+PPW_IDX_LSB-1:PPW_IDX_LSB];
            if (wv_r && wa_r == PPW_OFF_MASK) mask_r <= hwdata[7:0];
            if (wv_r && wa_r == PPW_OFF_SEL) sel_r <= hwdata[1:0];
        end
    end
    a_p0_pullup_inv: assert property (wv_r && wa_r == PPW_OFF_P0PU
        |=> port0_pullup_en == ~$past(hwdata[7:0])) else $error("port0 pull-up");
    a_p1_pullup_inv: assert property (wv_r && wa_r == PPW_OFF_P1PU
        |=> port1_pullup_en == ~$past(hwdata[6:0])) else $error("port1 pull-up");
    a_p3_pullup_inv: assert property (wv_r && wa_r == PPW_OFF_P3PU
        |=> port3_pullup_en == ~$past(hwdata[7:0])) else $error("port3 pull-up");
    a_pullup_reset: assert property ($fell(rst)
        |-> {port0_pullup_en, port1_pullup_en, port3_pullup_en} == 23'h7f_ffff)
        else $error("pull-ups after reset");
    a_pin7_combine: assert property (!$past(rst) && $past(sel_r[0])
        |-> port1_pin7_out == $past(and_w)) else $error("pin 7 combine");
    a_pin7_latch: assert property (!$past(rst) && !$past(sel_r[0])
        |-> port1_pin7_out == $past(port1_pin7_latch)) else $error("pin 7 latch");
    a_wake_ext: assert property (!$past(rst) && !$past(sel_r[1])
        |-> core_wake == ($past(ext_irq_line_a) || $past(ext_irq_line_b)))
        else $error("wake on lines");
    a_wake_sleep: assert property (!$past(rst) && $past(sel_r[1])
        |-> core_wake == $past(sleep_wake)) else $error("wake on timer");
    c_sel_write: cover property (wv_r && wa_r == PPW_OFF_SEL);
    c_and_high: cover property (sel_r[0] && and_w);
    c_timer_wake: cover property (sel_r[1] && sleep_wake);
endmodule // ppw_top_asserts
bind ppw_top ppw_top_asserts u_chk (.*);

// ---- ppw_top_tb.sv ----
// Testbench: register access, pull-ups, port 0 combining, pin 7 and wake select
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module ppw_top_tb;
    import ppw_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd_pend = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, e_v;
    logic [1:0]  htrans = '0;
    logic [2:0]  hsize = PPW_HSIZE_WORD;
    logic [11:0] drive = '0, d;
    logic [7:0]  v, m, port0_in, port0_pullup_en, port3_pullup_en;
    logic [6:0]  port1_pullup_en;
    logic hready, hreadyout, hresp, port1_pin7_latch, ext_irq_line_a, ext_irq_line_b;
    logic sleep_wake, port1_pin7_out, core_wake;
    int          fail_count = 0;
    int          comparisons = 0;
    logic [31:0] exp_q[$];
    assign hready = hreadyout;
    ppw_top dut (
        .mclk             (mclk),
        .rst              (rst),
        .hsel             (hsel),
        .haddr            (haddr),
        .htrans           (htrans),
        .hwrite           (hwrite),
        .hsize            (hsize),
        .hwdata           (hwdata),
        .hready           (hready),
        .hrdata           (hrdata),
        .hreadyout        (hreadyout),
        .hresp            (hresp),
        .port0_in         (port0_in),
        .port1_pin7_latch (port1_pin7_latch),
        .ext_irq_line_a   (ext_irq_line_a),
        .ext_irq_line_b   (ext_irq_line_b),
        .sleep_wake       (sleep_wake),
        .port0_pullup_en  (port0_pullup_en),
        .port1_pullup_en  (port1_pullup_en),
        .port3_pullup_en  (port3_pullup_en),
        .port1_pin7_out   (port1_pin7_out),
        .core_wake        (core_wake)
    );
    ppw_pin_env u_env (
        .drive            (drive),
        .port0_in         (port0_in),
        .port1_pin7_latch (port1_pin7_latch),
        .ext_irq_line_a   (ext_irq_line_a),
        .ext_irq_line_b   (ext_irq_line_b),
        .sleep_wake       (sleep_wake)
    );
    // =========
    // Bus tasks
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] dat);
        hsel <= 1'b1;
        // Word index to byte address
        haddr <= {22'h00_0000, a, 2'h0};
        htrans <= PPW_HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dat;
        do @(posedge mclk); while (hready !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, PPW_ZERO_WORD);
    endtask
    // Pin levels settle for two edges so the registered outputs have caught up
    task automatic pins(input logic [1:0] s, input logic [7:0] mk, input logic [11:0] dv);
        logic a;
        logic w;
        logic p;
        a = &(dv[7:0] | mk);
        p = s[0] ? a : dv[8];
        w = s[1] ? dv[11] : (dv[9] | dv[10]);
        drive <= dv;
        repeat (2) @(posedge mclk);
        `CHK("pin7", p, port1_pin7_out)
        `CHK("wake", w, core_wake)
        rd(PPW_OFF_STATUS, {29'h0000_0000, p, w, a});
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial forever #5 mclk = ~mclk;
    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        report_and_stop();
    end
    always @(posedge mclk) begin
        if (rd_pend && hready === 1'b1) begin
            e_v = exp_q.pop_front();
            `CHK("hrdata", e_v, hrdata)
        end
        if (hready === 1'b1) rd_pend <= !rst && hsel && htrans[1] && !hwrite;
    end
    initial begin
        void'($urandom(35));
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        `CHK("pu rst", 23'h7f_ffff, {port0_pullup_en, port1_pullup_en, port3_pullup_en})
        rd(PPW_OFF_MASK, 32'h0000_00ff);
        rd(PPW_OFF_SEL, PPW_ZERO_WORD);
        rd(PPW_OFF_P0PU, PPW_ZERO_WORD);
        rd(PPW_OFF_P1PU, PPW_ZERO_WORD);
        rd(PPW_OFF_P3PU, PPW_ZERO_WORD);
        rd(8'h90, PPW_ZERO_WORD);
        bus(PPW_OFF_SEL, 1'b1, 32'h0000_00ff);
        rd(PPW_OFF_SEL, 32'h0000_0003);
        v = {1'b0, 7'($urandom)};
        bus(PPW_OFF_P0PU, 1'b1, {24'h00_0000, v});
        bus(PPW_OFF_P1PU, 1'b1, {24'h00_0000, ~v});
        bus(PPW_OFF_P3PU, 1'b1, {24'h00_0000, v ^ 8'h5a});
        @(negedge mclk);
        `CHK("p0 pu", ~v, port0_pullup_en)
        `CHK("p1 pu", v[6:0], port1_pullup_en)
        `CHK("p3 pu", ~(v ^ 8'h5a), port3_pullup_en)
        @(posedge mclk);
        rd(PPW_OFF_P1PU, {25'h000_0000, ~v[6:0]});
        rd(PPW_OFF_P0PU, {24'h00_0000, v});
        for (int i = 0; i < 16; i++) begin
            d = 12'($urandom);
            m = i[2] ? ~d[7:0] : 8'($urandom);
            bus(PPW_OFF_MASK, 1'b1, {24'h00_0000, m});
            bus(PPW_OFF_SEL, 1'b1, {30'h0000_0000, i[1:0]});
            pins(i[1:0], m, d);
        end
        // Reset again mid-run: every written register must return to its reset value
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        `CHK("pu rst2", 23'h7f_ffff, {port0_pullup_en, port1_pullup_en, port3_pullup_en})
        rd(PPW_OFF_MASK, 32'h0000_00ff);
        rd(PPW_OFF_SEL, PPW_ZERO_WORD);
        rd(PPW_OFF_P1PU, PPW_ZERO_WORD);
        repeat (3) @(posedge mclk);
        report_and_stop();
    end
endmodule // ppw_top_tb
